// File: ssrm_bank.sv
// Top of the sensor status register bank: identity bytes, status and
// outcome flags, wheel output words and power-mode settings.
// Assumes the serial front end presents decoded byte reads and writes.
`timescale 1ns/1ns
module ssrm_bank #(
	parameter logic [7:0] PRODUCT_ID  = 8'h5A,  // Arbitrary value
	parameter logic [7:0] FIRMWARE_ID = 8'h01,  // Arbitrary value
	parameter logic [7:0] SILICON_ID  = 8'hA1   // Arbitrary value, differs per supply variant
) (
	input  wire logic                 ref_clk,      // Core clock 250 MHz
	input  wire logic                 rst,          // Synchronous reset, high
	input  wire ssrm_pkg::ssrm_req_t  req,          // Host byte access
	input  wire ssrm_pkg::ssrm_core_t core,         // Live sensor state
	output logic [7:0]                rdata_q,      // Read data, valid cycle after rd
	output logic                      rvalid_q,     // Read data strobe
	output logic [7:0]                rate_normal,  // Normal mode report rate
	output logic [7:0]                rate_low,     // Low power report rate
	output logic [7:0]                rate_ultra,   // Ultra-low power report rate
	output logic [7:0]                power_set,    // Power mode settings
	output logic [7:0]                channel_en,   // Active channels
	output logic [7:0]                general_set   // General system settings
);
	import ssrm_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Decode
	wire logic [NUM_SETTINGS-1:0] set_hit;
	wire logic [NUM_SETTINGS-1:0][7:0] set_bytes;
	wire logic ack_wr;
	wire logic status_rd;

	genvar gi;
	generate
		for (gi = 0; gi < NUM_SETTINGS; gi++) begin : g_dec
			// Only the settings window takes writes; read-only bytes ignore them
			assign set_hit[gi] = req.wr && (req.addr == ADDR_GENERAL_SET + 8'(gi));
		end
	endgenerate

	assign ack_wr    = set_hit[0] && req.wdata[BIT_ACK_RESET];
	assign status_rd = req.rd && (req.addr == ADDR_SYSTEM_STATUS);

	ssrm_settings u_settings (
		.ref_clk (ref_clk),
		.rst     (rst),
		.wr_sel  (set_hit),
		.wdata   (req.wdata),
		.bytes_q (set_bytes)
	);

	assign general_set = set_bytes[0];
	assign channel_en  = set_bytes[1];
	assign power_set   = set_bytes[2];
	assign rate_normal = set_bytes[3];
	assign rate_low    = set_bytes[4];
	assign rate_ultra  = set_bytes[5];

	////////////////////////////////////////////////////////////////////////////
	// Sticky flags: reset-seen and event pending
	logic reset_seen_q;
	logic reset_seen_d;
	logic event_q;
	logic event_d;

	// Reset sets the flag; only the host ack clears it
	assign reset_seen_d = ack_wr ? 1'b0 : reset_seen_q;

	// Event sets win over the read that clears it; a status read consumes the event
	assign event_d = core.event_pulse ? 1'b1 : (status_rd ? 1'b0 : event_q);

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			reset_seen_q <= 1'b1;
			event_q      <= 1'b0;
		end else begin
			reset_seen_q <= reset_seen_d;
			event_q      <= event_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Byte images of the status, touch and wheel registers, built live from the core and the sticky flags
	wire logic [7:0] status_byte;
	wire logic [7:0] touch_byte;
	wire logic [7:0] wheel_byte;

	assign status_byte = {reset_seen_q, 2'b00, core.power_state,
		core.tuning_busy, event_q, core.update_active};
	assign touch_byte  = {2'b00, core.touch_over[1], core.touch_over[0],
		2'b00, core.prox_over[1], core.prox_over[0]};
	// Direction is passed raw; filtering jitter is left to the host
	assign wheel_byte  = {core.wheel_move, core.wheel_neg, 6'h00};

	////////////////////////////////////////////////////////////////////////////
	// Read multiplexer; unmapped bytes read as zero
	logic [7:0] rmux;
	always_comb begin
		rmux = 8'h00;
		case (req.addr)
			ADDR_PRODUCT_CODE:   rmux = PRODUCT_ID;
			ADDR_FIRMWARE_CODE:  rmux = FIRMWARE_ID;
			ADDR_SILICON_CODE:   rmux = SILICON_ID;
			ADDR_SYSTEM_STATUS:  rmux = status_byte;
			ADDR_TOUCH_PROX:     rmux = touch_byte;
			ADDR_WHEEL_MOTION:   rmux = wheel_byte;
			ADDR_RATIO_LO:       rmux = core.ratio[7:0];
			ADDR_RATIO_HI:       rmux = core.ratio[15:8];
			ADDR_NUMER_LO:       rmux = core.numer[7:0];
			ADDR_NUMER_HI:       rmux = core.numer[15:8];
			ADDR_DENOM_LO:       rmux = core.denom[7:0];
			ADDR_DENOM_HI:       rmux = core.denom[15:8];
			ADDR_GENERAL_SET:    rmux = set_bytes[0];
			ADDR_CHANNEL_EN:     rmux = set_bytes[1];
			ADDR_POWER_MODE_SET: rmux = set_bytes[2];
			ADDR_RATE_NORMAL:    rmux = set_bytes[3];
			ADDR_RATE_LOW:       rmux = set_bytes[4];
			ADDR_RATE_ULTRA:     rmux = set_bytes[5];
			default:             rmux = 8'h00;
		endcase
	end

	// Read data register; only a status read changes stored content, by consuming the event
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rdata_q  <= 8'h00;
			rvalid_q <= 1'b0;
		end else begin
			rdata_q  <= req.rd ? rmux : rdata_q;
			rvalid_q <= req.rd;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks
	sequence s_ack;
		ack_wr;
	endsequence

	property p_reset_sets;
		@(posedge ref_clk) $fell(rst) |-> reset_seen_q;
	endproperty
	a_reset_sets: assert property (p_reset_sets) else $error("reset-seen not set after reset");

	property p_ack_clears;
		@(posedge ref_clk) disable iff (rst) s_ack |=> !reset_seen_q;
	endproperty
	a_ack_clears: assert property (p_ack_clears) else $error("ack did not clear reset-seen");

	property p_seen_holds;
		@(posedge ref_clk) disable iff (rst) reset_seen_q && !ack_wr |=> reset_seen_q;
	endproperty
	a_seen_holds: assert property (p_seen_holds) else $error("reset-seen dropped without ack");

	property p_status_read;
		@(posedge ref_clk) disable iff (rst) status_rd |=> rvalid_q && rdata_q[4:3] == $past(core.power_state)
			&& rdata_q[2] == $past(core.tuning_busy) && rdata_q[0] == $past(core.update_active);
	endproperty
	a_status_read: assert property (p_status_read) else $error("status fields wrong");

	property p_event_set;
		@(posedge ref_clk) disable iff (rst) core.event_pulse |=> event_q;
	endproperty
	a_event_set: assert property (p_event_set) else $error("event lost");

	property p_touch_read;
		@(posedge ref_clk) disable iff (rst) req.rd && req.addr == ADDR_TOUCH_PROX |=>
			rdata_q[5:4] == $past(core.touch_over) && rdata_q[1:0] == $past(core.prox_over);
	endproperty
	a_touch_read: assert property (p_touch_read) else $error("touch/prox flags wrong");

	property p_wheel_read;
		@(posedge ref_clk) disable iff (rst) req.rd && req.addr == ADDR_WHEEL_MOTION |=>
			rdata_q[7] == $past(core.wheel_move) && rdata_q[6] == $past(core.wheel_neg);
	endproperty
	a_wheel_read: assert property (p_wheel_read) else $error("wheel flags wrong");

	property p_ratio_hi;
		@(posedge ref_clk) disable iff (rst) req.rd && req.addr == ADDR_RATIO_HI |=> rdata_q == $past(core.ratio[15:8]);
	endproperty
	a_ratio_hi: assert property (p_ratio_hi) else $error("ratio high byte wrong");

	property p_rate_wr;
		@(posedge ref_clk) disable iff (rst) req.wr && req.addr == ADDR_RATE_LOW |=> rate_low == $past(req.wdata);
	endproperty
	a_rate_wr: assert property (p_rate_wr) else $error("low power rate not stored");

	property p_id_ro;
		@(posedge ref_clk) disable iff (rst) req.rd && req.addr == ADDR_PRODUCT_CODE |=> rdata_q == PRODUCT_ID;
	endproperty
	a_id_ro: assert property (p_id_ro) else $error("product code wrong");

	property p_fw_id;
		@(posedge ref_clk) disable iff (rst) req.rd && req.addr == ADDR_FIRMWARE_CODE |=> rdata_q == FIRMWARE_ID;
	endproperty
	a_fw_id: assert property (p_fw_id) else $error("firmware code wrong");

	property p_si_id;
		@(posedge ref_clk) disable iff (rst) req.rd && req.addr == ADDR_SILICON_CODE |=> rdata_q == SILICON_ID;
	endproperty
	a_si_id: assert property (p_si_id) else $error("silicon code wrong");

	property p_seen_read;
		@(posedge ref_clk) disable iff (rst) status_rd |=> rdata_q[BIT_RESET_SEEN] == $past(reset_seen_q);
	endproperty
	a_seen_read: assert property (p_seen_read) else $error("reset-seen bit wrong");

	property p_tuning_read;
		@(posedge ref_clk) disable iff (rst) status_rd |=> rdata_q[BIT_TUNING_BUSY] == $past(core.tuning_busy);
	endproperty
	a_tuning_read: assert property (p_tuning_read) else $error("tuning busy bit wrong");

	property p_event_read;
		@(posedge ref_clk) disable iff (rst) status_rd |=> rdata_q[BIT_EVENT] == $past(event_q);
	endproperty
	a_event_read: assert property (p_event_read) else $error("event bit wrong");

	property p_update_read;
		@(posedge ref_clk) disable iff (rst) status_rd |=> rdata_q[BIT_UPDATE] == $past(core.update_active);
	endproperty
	a_update_read: assert property (p_update_read) else $error("update active bit wrong");

	property p_status_pad;
		@(posedge ref_clk) disable iff (rst) status_rd |=> rdata_q[6:5] == 2'b00;
	endproperty
	a_status_pad: assert property (p_status_pad) else $error("status unused bits set");

	property p_event_clear;
		@(posedge ref_clk) disable iff (rst) status_rd && !core.event_pulse |=> !event_q;
	endproperty
	a_event_clear: assert property (p_event_clear) else $error("event not consumed");

	property p_ch0_touch;
		@(posedge ref_clk) disable iff (rst) req.rd && req.addr == ADDR_TOUCH_PROX |=>
			rdata_q[BIT_CH0_TOUCH] == $past(core.touch_over[0]);
	endproperty
	a_ch0_touch: assert property (p_ch0_touch) else $error("channel 0 touch wrong");

	property p_ch1_prox;
		@(posedge ref_clk) disable iff (rst) req.rd && req.addr == ADDR_TOUCH_PROX |=>
			rdata_q[BIT_CH1_PROX] == $past(core.prox_over[1]);
	endproperty
	a_ch1_prox: assert property (p_ch1_prox) else $error("channel 1 proximity wrong");

	property p_ch0_prox;
		@(posedge ref_clk) disable iff (rst) req.rd && req.addr == ADDR_TOUCH_PROX |=>
			rdata_q[BIT_CH0_PROX] == $past(core.prox_over[0]);
	endproperty
	a_ch0_prox: assert property (p_ch0_prox) else $error("channel 0 proximity wrong");

	property p_wheel_dir;
		@(posedge ref_clk) disable iff (rst) req.rd && req.addr == ADDR_WHEEL_MOTION |=>
			rdata_q[BIT_WHEEL_DIR] == $past(core.wheel_neg);
	endproperty
	a_wheel_dir: assert property (p_wheel_dir) else $error("wheel direction wrong");

	property p_ratio_lo;
		@(posedge ref_clk) disable iff (rst) req.rd && req.addr == ADDR_RATIO_LO |=> rdata_q == $past(core.ratio[7:0]);
	endproperty
	a_ratio_lo: assert property (p_ratio_lo) else $error("ratio low byte wrong");

	property p_numer_hi;
		@(posedge ref_clk) disable iff (rst) req.rd && req.addr == ADDR_NUMER_HI |=> rdata_q == $past(core.numer[15:8]);
	endproperty
	a_numer_hi: assert property (p_numer_hi) else $error("numerator high byte wrong");

	property p_denom_hi;
		@(posedge ref_clk) disable iff (rst) req.rd && req.addr == ADDR_DENOM_HI |=> rdata_q == $past(core.denom[15:8]);
	endproperty
	a_denom_hi: assert property (p_denom_hi) else $error("denominator high byte wrong");

	property p_rate_normal_wr;
		@(posedge ref_clk) disable iff (rst) req.wr && req.addr == ADDR_RATE_NORMAL |=> rate_normal == $past(req.wdata);
	endproperty
	a_rate_normal_wr: assert property (p_rate_normal_wr) else $error("normal rate not stored");

	property p_rate_ultra_wr;
		@(posedge ref_clk) disable iff (rst) req.wr && req.addr == ADDR_RATE_ULTRA |=> rate_ultra == $past(req.wdata);
	endproperty
	a_rate_ultra_wr: assert property (p_rate_ultra_wr) else $error("ultra-low rate not stored");

	property p_ack_self_clear;
		@(posedge ref_clk) disable iff (rst) s_ack |=> !general_set[BIT_ACK_RESET];
	endproperty
	a_ack_self_clear: assert property (p_ack_self_clear) else $error("ack bit stored");

	// A write outside the settings window must leave every stored byte alone
	property p_ro_ignored;
		@(posedge ref_clk) disable iff (rst) req.wr && set_hit == '0 |=> $stable(set_bytes);
	endproperty
	a_ro_ignored: assert property (p_ro_ignored) else $error("read-only write landed");

	property p_read_no_side;
		@(posedge ref_clk) disable iff (rst) req.rd && !req.wr && !status_rd && !core.event_pulse |=>
			$stable(set_bytes) && $stable(reset_seen_q) && $stable(event_q);
	endproperty
	a_read_no_side: assert property (p_read_no_side) else $error("read changed stored state");

	property p_rdata_hold;
		@(posedge ref_clk) disable iff (rst) !req.rd |=> $stable(rdata_q) && !rvalid_q;
	endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without read");

	property p_settings_reset;
		@(posedge ref_clk) $fell(rst) |-> set_bytes == '0 && !rvalid_q && rdata_q == 8'h00;
	endproperty
	a_settings_reset: assert property (p_settings_reset) else $error("settings not cleared by reset");

endmodule : ssrm_bank

// File: ssrm_host.sv
// Host model: byte reads and writes on the bank port.
// Assumes the bank takes requests on the rising ref_clk edge.
`timescale 1ns/1ns
module ssrm_host (
	input  wire logic           ref_clk,  // Core clock
	output ssrm_pkg::ssrm_req_t req,      // Byte access
	input  wire logic [7:0]     rdata_q,  // Read data
	input  wire logic           rvalid_q  // Read strobe
);
	import ssrm_pkg::*;

	////////////////////////////////////////////////////////////////
	// Idle bus at time zero
	initial req = '0;

	// One-cycle write strobe; released lines never repeat old values
	task automatic write_byte(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		#1;
		req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge ref_clk);
		#1;
		req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
	endtask : write_byte

	// Read strobe; data and strobe are taken after the taking edge
	task automatic read_byte(input logic [7:0] a, output logic [7:0] d,
		output logic v);
		@(posedge ref_clk);
		#1;
		req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge ref_clk);
		#1;
		req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hFF};
		v = rvalid_q;
		// Direction jitter is taken as reported, never filtered here
		d = rdata_q;
	endtask : read_byte

	// Acknowledge a seen reset through the general settings byte
	task automatic ack_reset();
		write_byte(ADDR_GENERAL_SET, 8'h40);
	endtask : ack_reset
endmodule : ssrm_host

// File: ssrm_pkg.sv
// Package for the sensor status register bank: offsets, field positions,
// reset values, state encodings and the carrier structs shared by the bank.
// Assumes a byte-addressed register port driven by the device's serial front end.
//
// Behaviour
// - A reset sets the reset-seen bit 7 of the status byte and it stays set until the host acknowledges it.
// - Status bits 4 to 3 give the present power state as normal, low, ultra-low or halt.
// - Status bit 2 is high while any channel runs automatic tuning and low otherwise.
// - Status bit 1 is set when a new event needs service and reads zero when nothing is pending.
// - Status bit 0 is high while a normal power update cycle runs and low otherwise.
// - Flag bit 5 follows whether the channel 1 delta is above its touch threshold.
// - Flag bit 4 follows whether the channel 0 delta is above its touch threshold.
// - Flag bit 1 follows whether the channel 1 delta is above its proximity threshold.
// - Flag bit 0 follows whether the channel 0 delta is above its proximity threshold.
// - Wheel flag bit 7 is high when magnet movement is detected and low otherwise.
// - Wheel flag bit 6 gives the rotation sense, zero positive and one negative.
// - Motion and direction flags react to tiny movements, so the host must tolerate direction jitter.
// - Bytes 0x00, 0x01 and 0x02 are read-only product, firmware and hardware codes, the last per supply variant.
// - Ratio, numerator and denominator are 16-bit values split low then high over 0x82 to 0x87.
// - Report rates for normal, low and ultra-low power sit at 0xD3, 0xD4 and 0xD5 beside the other settings.
// - Writing one to bit 6 of the general settings byte clears the reset-seen flag.
package ssrm_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Register offsets
	localparam logic [7:0] ADDR_PRODUCT_CODE   = 8'h00;
	localparam logic [7:0] ADDR_FIRMWARE_CODE  = 8'h01;
	localparam logic [7:0] ADDR_SILICON_CODE   = 8'h02;
	localparam logic [7:0] ADDR_SYSTEM_STATUS  = 8'h10;
	localparam logic [7:0] ADDR_TOUCH_PROX     = 8'h12;
	localparam logic [7:0] ADDR_WHEEL_MOTION   = 8'h14;
	localparam logic [7:0] ADDR_RATIO_LO       = 8'h82;
	localparam logic [7:0] ADDR_RATIO_HI       = 8'h83;
	localparam logic [7:0] ADDR_NUMER_LO       = 8'h84;
	localparam logic [7:0] ADDR_NUMER_HI       = 8'h85;
	localparam logic [7:0] ADDR_DENOM_LO       = 8'h86;
	localparam logic [7:0] ADDR_DENOM_HI       = 8'h87;
	localparam logic [7:0] ADDR_GENERAL_SET    = 8'hD0;
	localparam logic [7:0] ADDR_CHANNEL_EN     = 8'hD1;
	localparam logic [7:0] ADDR_POWER_MODE_SET = 8'hD2;
	localparam logic [7:0] ADDR_RATE_NORMAL    = 8'hD3;
	localparam logic [7:0] ADDR_RATE_LOW       = 8'hD4;
	localparam logic [7:0] ADDR_RATE_ULTRA     = 8'hD5;

	////////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int unsigned BIT_RESET_SEEN   = 7;
	localparam int unsigned BIT_PWR_HI       = 4;
	localparam int unsigned BIT_PWR_LO       = 3;
	localparam int unsigned BIT_TUNING_BUSY  = 2;
	localparam int unsigned BIT_EVENT        = 1;
	localparam int unsigned BIT_UPDATE       = 0;
	localparam int unsigned BIT_CH1_TOUCH    = 5;
	localparam int unsigned BIT_CH0_TOUCH    = 4;
	localparam int unsigned BIT_CH1_PROX     = 1;
	localparam int unsigned BIT_CH0_PROX     = 0;
	localparam int unsigned BIT_WHEEL_MOVE   = 7;
	localparam int unsigned BIT_WHEEL_DIR    = 6;
	localparam int unsigned BIT_ACK_RESET    = 6;
	localparam int unsigned NUM_SETTINGS     = 6;

	////////////////////////////////////////////////////////////////////////////
	// Reset values of the writable settings bytes
	localparam logic [7:0] RST_SETTING = 8'h00;

	////////////////////////////////////////////////////////////////////////////
	// Power states
	typedef enum logic [1:0] {
		SSRM_PWR_NORMAL = 2'b00,
		SSRM_PWR_LOW    = 2'b01,
		SSRM_PWR_ULTRA  = 2'b10,
		SSRM_PWR_HALT   = 2'b11
	} ssrm_pwr_t;

	////////////////////////////////////////////////////////////////////////////
	// Carriers
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} ssrm_req_t;

	typedef struct packed {
		ssrm_pwr_t  power_state;
		logic       tuning_busy;
		logic       event_pulse;
		logic       update_active;
		logic [1:0] touch_over;   // Bit 1 channel 1, bit 0 channel 0
		logic [1:0] prox_over;    // Bit 1 channel 1, bit 0 channel 0
		logic       wheel_move;
		logic       wheel_neg;
		logic [15:0] ratio;
		logic [15:0] numer;
		logic [15:0] denom;
	} ssrm_core_t;

endpackage : ssrm_pkg

// File: ssrm_settings.sv
// Writable settings bytes of the bank at 0xD0 to 0xD5.
// Assumes one-cycle write strobes from the register port.
`timescale 1ns/1ns
module ssrm_settings (
	input  wire logic                               ref_clk,  // Core clock
	input  wire logic                               rst,      // Synchronous reset, high
	input  wire logic [ssrm_pkg::NUM_SETTINGS-1:0]  wr_sel,   // One-hot byte write strobe
	input  wire logic [7:0]                         wdata,    // Write data
	output logic [ssrm_pkg::NUM_SETTINGS-1:0][7:0]  bytes_q   // Stored settings
);
	import ssrm_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// One flop byte per setting; the ack bit is self-clearing in the general byte
	genvar gi;
	generate
		for (gi = 0; gi < NUM_SETTINGS; gi++) begin : g_set
			always_ff @(posedge ref_clk) begin
				if (rst) begin
					bytes_q[gi] <= RST_SETTING;
				end else if (wr_sel[gi]) begin
					bytes_q[gi] <= (gi == 0) ? (wdata & ~(8'h01 << BIT_ACK_RESET)) : wdata;
				end
			end
		end
	endgenerate

endmodule : ssrm_settings

// File: test_ssrm_bank.sv
// Self-checking bench for the status register bank.
// Assumes ssrm_host drives the port and the bench drives core state.
`timescale 1ns/1ns
module test_ssrm_bank;
	import ssrm_pkg::*;
	localparam logic [7:0] PID = 8'h3C;  // Arbitrary value
	localparam logic [7:0] FID = 8'h07;  // Arbitrary value
	localparam logic [7:0] SID = 8'hC5;  // Arbitrary value
	logic            ref_clk;
	logic            rst;
	ssrm_req_t       req;
	ssrm_core_t      core;
	logic [7:0]      rdata_q;
	logic            rvalid_q;
	wire [5:0][7:0]  sets;
	int              num_errors;
	int              n_checks;
	logic [63:0]     r;
	logic [7:0]      d;
	logic [7:0]      ro_addr [13] = '{8'h00, 8'h01, 8'h02, 8'h10, 8'h12,
		8'h14, 8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'h87, 8'h11};

	////////////////////////////////////////////////////////////////
	ssrm_bank #(.PRODUCT_ID(PID), .FIRMWARE_ID(FID), .SILICON_ID(SID)) dut (
		.ref_clk    (ref_clk),
		.rst        (rst),
		.req        (req),
		.core       (core),
		.rdata_q    (rdata_q),
		.rvalid_q   (rvalid_q),
		.general_set(sets[0]),
		.channel_en (sets[1]),
		.power_set  (sets[2]),
		.rate_normal(sets[3]),
		.rate_low   (sets[4]),
		.rate_ultra (sets[5])
	);
	ssrm_host host (
		.ref_clk (ref_clk),
		.req     (req),
		.rdata_q (rdata_q),
		.rvalid_q(rvalid_q)
	);

	////////////////////////////////////////////////////////////////
	// Clock and hang guard; 3000 cycles is well above the run
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	initial begin
		repeat (3000) @(posedge ref_clk);
		num_errors++;
		results();
	end

	// Expected byte at an address from the live core state
	function automatic logic [7:0] exp_byte(logic [7:0] a, ssrm_core_t c,
		logic s, logic e);
		case (a)
			8'h00: return PID;
			8'h01: return FID;
			8'h02: return SID;
			8'h10: return {s, 2'b00, c.power_state, c.tuning_busy, e, c.update_active};
			8'h12: return {2'b00, c.touch_over, 2'b00, c.prox_over};
			8'h14: return {c.wheel_move, c.wheel_neg, 6'h00};
			8'h82: return c.ratio[7:0];
			8'h83: return c.ratio[15:8];
			8'h84: return c.numer[7:0];
			8'h85: return c.numer[15:8];
			8'h86: return c.denom[7:0];
			8'h87: return c.denom[15:8];
			default: return 8'h00;
		endcase
	endfunction : exp_byte

	task automatic chk8(string n, logic [7:0] e, logic [7:0] g);
		n_checks++;
		if (g !== e) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask : chk8

	task automatic chk1(string n, logic e, logic g);
		n_checks++;
		if (g !== e) begin
			num_errors++;
			$display("MISMATCH %s expected %b seen %b", n, e, g);
		end
	endtask : chk1

	// Read one byte and compare strobe and data
	task automatic rd_chk(logic [7:0] a, logic [7:0] e);
		logic [7:0] g;
		logic       v;
		host.read_byte(a, g, v);
		chk1("rvalid", 1'b1, v);
		chk8($sformatf("byte %h", a), e, g);
	endtask : rd_chk

	task automatic results();
		if (num_errors == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : results

	////////////////////////////////////////////////////////////////
	// Main sequence: reset, random live state, event, ack, settings
	initial begin
		void'($urandom(32'hD24C));
		rst = 1'b1;
		core = '0;
		num_errors = 0;
		n_checks = 0;
		for (int p = 0; p < 2; p++) begin
			repeat (5) @(posedge ref_clk);
			#1;
			rst = 1'b0;
			rd_chk(8'h10, exp_byte(8'h10, core, 1'b1, 1'b0));
			for (int k = 0; k < 6; k++) begin
				chk8("setting", 8'h00, sets[k]);
			end
			if (p == 0) begin
				// Random state; writes to read-only places must not land
				for (int i = 0; i < 40; i++) begin
					r = {$urandom(), $urandom()};
					core = r[$bits(ssrm_core_t)-1:0];
					core.event_pulse = 1'b0;
					core.power_state = ssrm_pwr_t'(i[1:0]);
					host.write_byte(ro_addr[i % 13], r[63:56]);
					foreach (ro_addr[k]) begin
						rd_chk(ro_addr[k], exp_byte(ro_addr[k], core, 1'b1, 1'b0));
					end
				end
				// Event is sticky until status is read
				core.event_pulse = 1'b1;
				@(posedge ref_clk);
				#1;
				core.event_pulse = 1'b0;
				rd_chk(8'h12, exp_byte(8'h12, core, 1'b1, 1'b0));
				rd_chk(8'h10, exp_byte(8'h10, core, 1'b1, 1'b1));
				rd_chk(8'h10, exp_byte(8'h10, core, 1'b1, 1'b0));
				// Event on the same edge as a status read survives the read
				fork
					rd_chk(8'h10, exp_byte(8'h10, core, 1'b1, 1'b0));
					begin
						@(posedge ref_clk);
						#1;
						core.event_pulse = 1'b1;
						@(posedge ref_clk);
						#1;
						core.event_pulse = 1'b0;
					end
				join
				rd_chk(8'h10, exp_byte(8'h10, core, 1'b1, 1'b1));
				host.ack_reset();
				rd_chk(8'h10, exp_byte(8'h10, core, 1'b0, 1'b0));
				rd_chk(8'hD0, 8'h00);
				// Settings bytes; ack bit kept clear in general byte
				for (int k = 0; k < 6; k++) begin
					d = 8'($urandom()) & ((k == 0) ? 8'hBF : 8'hFF);
					host.write_byte(8'hD0 + 8'(k), d);
					chk8("setting", d, sets[k]);
					rd_chk(8'hD0 + 8'(k), d);
				end
				rst = 1'b1;
			end
		end
		results();
	end
endmodule : test_ssrm_bank
